// ===== verilog/tbb_pkg.sv
package tbb_pkg;

    // Byte address width of the SRAM, legal from 5 to 32
    localparam int          SRAM_ADDR_WIDTH_PARAM = 16;
    localparam int          WA          = SRAM_ADDR_WIDTH_PARAM - 2;
    localparam logic [WA-1:0] PTR_RST   = '0;
    localparam logic [WA-1:0] PKT_STEP  = WA'(2);
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;

    // Bus encodings
    localparam int          TRANS_ACTIVE_BIT = 1;
    localparam logic [2:0]  SIZE_BYTE   = 3'h0;
    localparam logic [2:0]  SIZE_HALF   = 3'h1;
    localparam logic        RESP_OKAY   = 1'b0;
    localparam logic        RESP_ERROR  = 1'b1;

    // Flow-change kinds reported by the core
    typedef enum logic [2:0] {
        EV_BRANCH     = 3'h0,
        EV_COND       = 3'h1,
        EV_EXC_ENTRY  = 3'h2,
        EV_DEBUG_PC   = 3'h3,
        EV_LOCKUP     = 3'h4,
        EV_EXCEPTION_RETURN_CODE = 3'h5
    } tbb_kind_t;

    // Packet writer states
    typedef enum logic [4:0] {
        PK_IDLE = 5'b00001,
        PK_SRC  = 5'b00010,
        PK_DST  = 5'b00100,
        PK_RSRC = 5'b01000,
        PK_RDST = 5'b10000
    } tbb_pk_state_t;

    // Byte lanes touched by a transfer
    function automatic logic [3:0] tbb_lanes(input logic [2:0] size, input logic [1:0] a);
        logic [3:0] l;
        l = 4'hf;
        if (size == SIZE_BYTE) begin
            l = 4'h1 << a;
        end else if (size == SIZE_HALF) begin
            l = a[1] ? 4'hc : 4'h3;
        end
        return l;
    endfunction : tbb_lanes

endpackage : tbb_pkg

// ===== verilog/tbb_trace_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tbb_trace_if;
    import tbb_pkg::*;
    logic                 ev_valid;
    tbb_kind_t            ev_kind;
    logic                 ev_taken;
    logic [31:0]          ev_src;
    logic [31:0]          ev_dst;
    logic [31:0]          ev_code;
    logic                 trace_on;
    logic                 ev_ready;
    logic                 wr_en;
    logic [WA-1:0]        wr_addr;
    logic [31:0]          wr_data;

    modport pack (input ev_valid, ev_kind, ev_taken, ev_src, ev_dst, ev_code, trace_on,
                  output ev_ready, wr_en, wr_addr, wr_data);
    modport ctrl (output ev_valid, ev_kind, ev_taken, ev_src, ev_dst, ev_code, trace_on,
                  input ev_ready, wr_en, wr_addr, wr_data);
endinterface : tbb_trace_if
`default_nettype wire

// ===== verilog/tbb_packer.sv
`timescale 1ns/1ps
`default_nettype none
module tbb_packer (
    // Clock and reset
    input  wire logic    core_clk,
    input  wire logic    rst_n,
    // Flow reports in, packet words out
    tbb_trace_if.pack    tif
);
    import tbb_pkg::*;

    tbb_pk_state_t  st_reg, st_next;
    logic [31:0]    src_reg, src_next, dst_reg, dst_next;
    logic [31:0]    rsrc_reg, rsrc_next, rdst_reg, rdst_next;
    logic [WA-1:0]  ptr_reg, ptr_next;
    logic           start_reg, start_next, on_reg, rdy_reg, rdy_next;
    logic           accept, rise, flag_s;

    // Only flow changes enter; taken test drops untaken conditionals
    assign accept = (st_reg == PK_IDLE) & tif.ev_valid & tif.trace_on
                  & ((tif.ev_kind != EV_COND) | tif.ev_taken);
    assign rise   = tif.trace_on & ~on_reg;
    assign flag_s = start_reg | rise;

    // Packet assembly and sequencing
    always_comb begin
        st_next    = st_reg;
        src_next   = src_reg;
        dst_next   = dst_reg;
        rsrc_next  = rsrc_reg;
        rdst_next  = rdst_reg;
        ptr_next   = ptr_reg;
        start_next = (start_reg | rise) & ~accept;
        unique case (st_reg)
            PK_IDLE: begin
                if (accept) begin
                    st_next  = PK_SRC;
                    dst_next = {tif.ev_dst[31:1], flag_s};
                    unique case (tif.ev_kind)
                        EV_EXC_ENTRY, EV_DEBUG_PC, EV_LOCKUP: begin
                            src_next = {tif.ev_src[31:1], 1'b1};
                        end
                        EV_EXCEPTION_RETURN_CODE: begin
                            src_next  = {tif.ev_src[31:1], 1'b0};
                            dst_next  = {tif.ev_code[31:1], flag_s};
                            rsrc_next = {tif.ev_code[31:1], 1'b1};
                            rdst_next = {tif.ev_dst[31:1], 1'b0};
                        end
                        default: begin
                            src_next = {tif.ev_src[31:1], 1'b0};
                        end
                    endcase
                end
            end
            PK_SRC:  st_next = PK_DST;
            PK_DST: begin
                ptr_next = ptr_reg + PKT_STEP;
                st_next  = (src_reg[0] == 1'b0 && rsrc_reg[0]) ? PK_RSRC : PK_IDLE;
            end
            PK_RSRC: st_next = PK_RDST;
            // Return marker doubles as the origin flag, so it is only dropped once written
            PK_RDST: begin
                ptr_next     = ptr_reg + PKT_STEP;
                st_next      = PK_IDLE;
                rsrc_next[0] = 1'b0;
            end
        endcase
        rdy_next = (st_next == PK_IDLE);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg    <= PK_IDLE;
            src_reg   <= WORD_RST;
            dst_reg   <= WORD_RST;
            rsrc_reg  <= WORD_RST;
            rdst_reg  <= WORD_RST;
            ptr_reg   <= PTR_RST;
            start_reg <= 1'b0;
            on_reg    <= 1'b0;
            rdy_reg   <= 1'b0;
        end else begin
            st_reg    <= st_next;
            src_reg   <= src_next;
            dst_reg   <= dst_next;
            rsrc_reg  <= rsrc_next;
            rdst_reg  <= rdst_next;
            ptr_reg   <= ptr_next;
            start_reg <= start_next;
            on_reg    <= tif.trace_on;
            rdy_reg   <= rdy_next;
        end
    end

    // Even word for source, odd word for target; only flow words ever leave
    assign tif.ev_ready = rdy_reg;
    assign tif.wr_en    = (st_reg != PK_IDLE);
    assign tif.wr_addr  = ((st_reg == PK_DST) || (st_reg == PK_RDST)) ? (ptr_reg | WA'(1)) : ptr_reg;
    assign tif.wr_data  = (st_reg == PK_SRC)  ? src_reg  :
                          (st_reg == PK_DST)  ? dst_reg  :
                          (st_reg == PK_RSRC) ? rsrc_reg : rdst_reg;

endmodule : tbb_packer
`default_nettype wire

// ===== verilog/tbb_trace_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module tbb_trace_bridge #(
    parameter bit SEC_EXT = 1'b0
) (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    // Flow-change reports from the core
    input  wire logic                       trc_valid,
    input  wire tbb_pkg::tbb_kind_t         trc_kind,
    input  wire logic                       trc_taken,
    input  wire logic [31:0]                trc_src,
    input  wire logic [31:0]                trc_dst,
    input  wire logic [31:0]                exception_return_code,
    output logic                            trc_ready,
    // Trace control
    input  wire logic                       trace_enable_bit,
    input  wire logic                       noninvasive_debug_permit,
    // Non-secure region programming
    input  wire logic [tbb_pkg::WA-1:0]     ns_region_base,
    input  wire logic                       ns_read_perm,
    input  wire logic                       ns_write_perm,
    // Base locator
    input  wire logic [31:0]                sram_base_input,
    output logic [31:0]                     sram_base_locator,
    // Bus slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic                       hnonsec,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // Synchronous SRAM
    output logic                            sram_cs,
    output logic [3:0]                      sram_wen,
    output logic [tbb_pkg::WA-1:0]          sram_addr,
    output logic [31:0]                     sram_wdata,
    input  wire logic [31:0]                sram_rdata
);
    import tbb_pkg::*;

    tbb_trace_if tif ();

    // Permit pin synchroniser and base locator register
    logic           permit_meta_reg;
    logic           permit_sync_reg;
    logic [31:0]    base_reg;

    // Data phase state
    logic           dp_valid_reg, dp_valid_next;
    logic           dp_write_reg, dp_write_next;
    logic           dp_err_reg,   dp_err_next;
    logic [WA-1:0]  dp_addr_reg,  dp_addr_next;
    logic [3:0]     dp_be_reg,    dp_be_next;
    logic           rdy_reg,      rdy_next;
    logic           resp_reg,     resp_next;

    // Write buffer
    logic           wb_valid_reg, wb_valid_next;
    logic [WA-1:0]  wb_addr_reg,  wb_addr_next;
    logic [3:0]     wb_be_reg,    wb_be_next;
    logic [31:0]    wb_data_reg,  wb_data_next;

    // Per-cycle arbitration terms
    logic           a_take;
    logic [WA-1:0]  a_word;
    logic [3:0]     a_be;
    logic           a_ok;
    logic           trace_use;
    logic           rd_new;
    logic           rd_wait;
    logic           rd_issue;
    logic [WA-1:0]  rd_addr;
    logic           dp_done;
    logic           wcap;
    logic           drain;
    logic           wdirect;
    logic           fwd_hit;

    // Packet writer
    tbb_packer u_packer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tif      (tif)
    );

    // Trace runs only with permit and enable both high
    assign tif.ev_valid = trc_valid;
    assign tif.ev_kind  = trc_kind;
    assign tif.ev_taken = trc_taken;
    assign tif.ev_src   = trc_src;
    assign tif.ev_dst   = trc_dst;
    assign tif.ev_code  = exception_return_code;
    assign tif.trace_on = trace_enable_bit & permit_sync_reg;

    // Permit is a pin; two flops before use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            permit_meta_reg <= 1'b0;
            permit_sync_reg <= 1'b0;
            base_reg        <= WORD_RST;
        end else begin
            permit_meta_reg <= noninvasive_debug_permit;
            permit_sync_reg <= permit_meta_reg;
            base_reg        <= sram_base_input;
        end
    end

    // Address phase decode; word address drops the two lane bits
    assign a_take = hsel & htrans[TRANS_ACTIVE_BIT] & hready;
    assign a_word = haddr[SRAM_ADDR_WIDTH_PARAM-1:2];
    assign a_be   = tbb_lanes(hsize, haddr[1:0]);

    // Secure masters see everything, non-secure only its region
    always_comb begin
        a_ok = 1'b1;
        if (SEC_EXT && hnonsec) begin
            a_ok = (a_word >= ns_region_base)
                 & (hwrite ? ns_write_perm : ns_read_perm);
        end
    end

    // SRAM arbitration: trace, then reads, then buffered writes
    assign trace_use = tif.wr_en;
    assign rd_new    = a_take & ~hwrite & a_ok;
    assign rd_wait   = dp_valid_reg & ~dp_write_reg & ~dp_err_reg & ~rdy_reg;
    assign rd_issue  = ~trace_use & (rd_new | rd_wait);
    assign rd_addr   = rd_wait ? dp_addr_reg : a_word;
    assign dp_done   = dp_valid_reg & rdy_reg;
    assign wcap      = dp_done & dp_write_reg & ~dp_err_reg;
    assign drain     = ~trace_use & ~rd_issue & wb_valid_reg;
    assign wdirect   = ~trace_use & ~rd_issue & ~wb_valid_reg & wcap;

    // Write buffer: a blocked write parks here so a read can pass
    always_comb begin
        wb_valid_next = wb_valid_reg;
        wb_addr_next  = wb_addr_reg;
        wb_be_next    = wb_be_reg;
        wb_data_next  = wb_data_reg;
        if (wcap && !wdirect) begin
            wb_valid_next = 1'b1;
            wb_addr_next  = dp_addr_reg;
            wb_be_next    = dp_be_reg;
            wb_data_next  = hwdata;
        end else if (drain) begin
            wb_valid_next = 1'b0;
        end
    end

    // Data phase tracking and ready/response
    always_comb begin
        dp_valid_next = dp_valid_reg;
        dp_write_next = dp_write_reg;
        dp_err_next   = dp_err_reg;
        dp_addr_next  = dp_addr_reg;
        dp_be_next    = dp_be_reg;
        rdy_next      = 1'b1;
        resp_next     = RESP_OKAY;
        if (a_take) begin
            dp_valid_next = 1'b1;
            dp_write_next = hwrite;
            dp_err_next   = ~a_ok;
            dp_addr_next  = a_word;
            dp_be_next    = a_be;
            if (!a_ok) begin
                // First cycle of the two-cycle error answer
                rdy_next  = 1'b0;
                resp_next = RESP_ERROR;
            end else if (hwrite) begin
                rdy_next  = ~wb_valid_next;
            end else begin
                rdy_next  = rd_issue;
            end
        end else if (dp_valid_reg && !rdy_reg) begin
            if (dp_err_reg) begin
                resp_next = RESP_ERROR;
            end else if (dp_write_reg) begin
                rdy_next  = ~wb_valid_next;
            end else begin
                rdy_next  = rd_issue;
            end
        end else if (dp_done) begin
            dp_valid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_err_reg   <= 1'b0;
            dp_addr_reg  <= PTR_RST;
            dp_be_reg    <= 4'h0;
            rdy_reg      <= 1'b1;
            resp_reg     <= RESP_OKAY;
            wb_valid_reg <= 1'b0;
            wb_addr_reg  <= PTR_RST;
            wb_be_reg    <= 4'h0;
            wb_data_reg  <= WORD_RST;
        end else begin
            dp_valid_reg <= dp_valid_next;
            dp_write_reg <= dp_write_next;
            dp_err_reg   <= dp_err_next;
            dp_addr_reg  <= dp_addr_next;
            dp_be_reg    <= dp_be_next;
            rdy_reg      <= rdy_next;
            resp_reg     <= resp_next;
            wb_valid_reg <= wb_valid_next;
            wb_addr_reg  <= wb_addr_next;
            wb_be_reg    <= wb_be_next;
            wb_data_reg  <= wb_data_next;
        end
    end

    // SRAM port is driven in the same cycle to keep reads at zero wait
    always_comb begin
        sram_cs    = 1'b0;
        sram_wen   = 4'h0;
        sram_addr  = rd_addr;
        sram_wdata = WORD_RST;
        if (trace_use) begin
            sram_cs    = 1'b1;
            sram_wen   = 4'hf;
            sram_addr  = tif.wr_addr;
            sram_wdata = tif.wr_data;
        end else if (rd_issue) begin
            sram_cs    = 1'b1;
        end else if (drain) begin
            sram_cs    = 1'b1;
            sram_wen   = wb_be_reg;
            sram_addr  = wb_addr_reg;
            sram_wdata = wb_data_reg;
        end else if (wdirect) begin
            sram_cs    = 1'b1;
            sram_wen   = dp_be_reg;
            sram_addr  = dp_addr_reg;
            sram_wdata = hwdata;
        end
    end

    // Read data takes parked write bytes so a read never sees stale data
    assign fwd_hit = wb_valid_reg & (wb_addr_reg == dp_addr_reg);
    always_comb begin
        hrdata = sram_rdata;
        for (int i = 0; i < 4; i++) begin
            if (fwd_hit && wb_be_reg[i]) begin
                hrdata[8*i +: 8] = wb_data_reg[8*i +: 8];
            end
        end
    end

    // Registered outputs
    assign trc_ready         = tif.ev_ready;
    assign sram_base_locator = base_reg;
    assign hreadyout         = rdy_reg;
    assign hresp             = resp_reg;

endmodule : tbb_trace_bridge
`default_nettype wire

// ===== verification/tbb_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbb_sram_model (
    // Clock
    input  wire logic                   core_clk,
    // Synchronous word port
    input  wire logic                   sram_cs,
    input  wire logic [3:0]             sram_wen,
    input  wire logic [tbb_pkg::WA-1:0] sram_addr,
    input  wire logic [31:0]            sram_wdata,
    output logic      [31:0]            sram_rdata
);
    logic [31:0] mem [int];

    initial sram_rdata = 32'h5a5a_5a5a;

    // Data valid only the cycle after a read; toggled otherwise so stale words never match
    always @(posedge core_clk) begin
        if (sram_cs && sram_wen == 4'h0) begin
            sram_rdata <= mem[int'(sram_addr)];
        end else begin
            sram_rdata <= ~sram_rdata;
        end
        for (int i = 0; i < 4; i++) begin
            if (sram_cs && sram_wen[i]) begin
                mem[int'(sram_addr)][8*i+:8] = sram_wdata[8*i+:8];
            end
        end
    end
endmodule : tbb_sram_model
`default_nettype wire

// ===== verification/tbb_bridge_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tbb_bridge_monitor
    import tbb_pkg::*;
(
    // Clock and reset
    input wire logic          core_clk,
    input wire logic          rst_n,
    // Trace side
    input wire logic          trc_valid,
    input wire tbb_kind_t     trc_kind,
    input wire logic [31:0]   trc_src,
    input wire logic          trc_ready,
    input wire logic [31:0]   sram_base_input,
    input wire logic [31:0]   sram_base_locator,
    // Bus side
    input wire logic          hsel,
    input wire logic [31:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic          hresp,
    // SRAM side
    input wire logic          sram_cs,
    input wire logic [3:0]    sram_wen,
    input wire logic [WA-1:0] sram_addr,
    input wire logic [31:0]   sram_wdata
);
    default clocking mon_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Read taken while the SRAM has no trace write pending
    wire logic free_rd = hsel && htrans[1] && hready && !hwrite && trc_ready && !trc_valid;

    // Source word at even address, destination word in the very next cycle
    sequence pkt_words;
        sram_cs && sram_wen == 4'hf && !sram_addr[0]
        ##1 sram_cs && sram_wen == 4'hf && sram_addr == $past(sram_addr) + 1'b1;
    endsequence

    pkt_pair_a: assert property ($fell(trc_ready) |-> pkt_words)
        else $error("packet words not paired");
    src_word_a: assert property ($fell(trc_ready) |-> sram_wdata[31:1] == $past(trc_src[31:1]))
        else $error("source word wrong");
    origin_flag_a: assert property ($fell(trc_ready) |->
        sram_wdata[0] == ($past(trc_kind) inside {EV_EXC_ENTRY, EV_DEBUG_PC, EV_LOCKUP}))
        else $error("origin flag wrong");
    busy_span_a: assert property ($fell(trc_ready) |-> ##1 !trc_ready ##[1:3] trc_ready)
        else $error("packer busy span wrong");
    zero_wait_a: assert property (free_rd |=> hreadyout)
        else $error("wait state without trace write");
    read_issue_a: assert property (free_rd |-> sram_cs && sram_wen == 4'h0 && sram_addr == haddr[WA+1:2])
        else $error("read not issued to SRAM");
    wait_bound_a: assert property (!hreadyout |-> ##[1:12] hreadyout)
        else $error("bus stall too long");
    resp_okay_a: assert property (hreadyout |-> hresp == RESP_OKAY)
        else $error("error response without security");
    locator_a: assert property (sram_base_locator == $past(sram_base_input))
        else $error("base locator mismatch");
endmodule : tbb_bridge_monitor

bind tbb_trace_bridge tbb_bridge_monitor u_tbb_bridge_monitor (.core_clk, .rst_n, .trc_valid, .trc_kind,
    .trc_src, .trc_ready, .sram_base_input, .sram_base_locator, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .sram_cs, .sram_wen, .sram_addr, .sram_wdata);
`default_nettype wire

// ===== verification/tbb_trace_bridge_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tbb_trace_bridge_tb;
    import tbb_pkg::*;
    logic          core_clk = 1'b0, rst_n = 1'b0, trc_valid = 1'b0, trc_taken = 1'b0, hsel = 1'b0;
    logic          trace_enable_bit = 1'b0, noninvasive_debug_permit = 1'b0, hwrite = 1'b0, hnonsec = 1'b0;
    logic          trc_ready, hreadyout, hresp, sram_cs, s_pend = 1'b0, ph = 1'b0;
    tbb_kind_t     trc_kind = EV_BRANCH;
    logic [31:0]   trc_src = '0, trc_dst = '0, exception_return_code = '0, sram_base_input = '0;
    logic [31:0]   haddr = '0, hwdata = '0, hrdata, sram_base_locator, sram_wdata, sram_rdata, ba;
    logic [1:0]    htrans = 2'h0;
    logic [2:0]    hsize = 3'h2, bsz;
    logic [3:0]    sram_wen;
    logic [WA-1:0] sram_addr;
    wire logic     hready;
    int            error_cnt = 0, cmp_count = 0, ptr = 0;
    logic [31:0]   em [int];
    logic [31:0]   exq [$];

    assign hready = hreadyout;
    always #4 core_clk = ~core_clk;

    tbb_trace_bridge u_tbb_trace_bridge (.core_clk, .rst_n, .trc_valid, .trc_kind, .trc_taken, .trc_src,
        .trc_dst, .exception_return_code, .trc_ready, .trace_enable_bit, .noninvasive_debug_permit,
        .ns_region_base('0), .ns_read_perm(1'b0), .ns_write_perm(1'b0), .sram_base_input, .sram_base_locator,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hnonsec, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .sram_cs, .sram_wen, .sram_addr, .sram_wdata, .sram_rdata);
    tbb_sram_model u_tbb_sram_model (.core_clk, .sram_cs, .sram_wen, .sram_addr, .sram_wdata, .sram_rdata);

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    // Predicted packet; start flag consumed by the first one
    task automatic pk(input logic [31:0] s, input logic a, input logic [31:0] d);
        em[ptr] = {s[31:1], a};
        em[ptr + 1] = {d[31:1], s_pend};
        s_pend = 1'b0;
        ptr += 2;
    endtask : pk

    // One flow report, held until the packer is seen ready
    task automatic trc(input tbb_kind_t k, input logic tk, input logic [31:0] s, d, c);
        @(posedge core_clk);
        trc_valid <= 1'b1;
        trc_kind <= k;
        trc_taken <= tk;
        trc_src <= s;
        trc_dst <= d;
        exception_return_code <= c;
        sram_base_input <= $urandom;
        do @(posedge core_clk); while (trc_ready !== 1'b1);
        trc_valid <= 1'b0;
        if (trace_enable_bit && noninvasive_debug_permit && (k != EV_COND || tk)) begin
            pk(s, k inside {EV_EXC_ENTRY, EV_DEBUG_PC, EV_LOCKUP}, k == EV_EXCEPTION_RETURN_CODE ? c : d);
            if (k == EV_EXCEPTION_RETURN_CODE) pk(c, 1'b1, d);
        end
    endtask : trc

    // Non-pipelined bus transfer; read expectations go to the queue
    task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d);
        logic [3:0] ln;
        ln = (sz == 3'h0) ? 4'h1 << a[1:0] : (sz == 3'h1) ? 4'h3 << {a[1], 1'b0} : 4'hf;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= sz;
        hnonsec <= 1'($urandom);
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) exq.push_back(em[int'(a[31:2])]);
        for (int i = 0; i < 4; i++) if (w && ln[i]) em[int'(a[31:2])][8*i+:8] = d[8*i+:8];
        do @(posedge core_clk); while (hready !== 1'b1);
    endtask : bus

    // Data-phase watcher: oldest expectation against what the bus returns
    always @(posedge core_clk) begin
        if (ph && hreadyout === 1'b1) begin
            chk("hresp", {31'h0, hresp}, 32'h0);
            chk("hrdata", hrdata, exq.pop_front());
        end
        ph <= (hsel && htrans[1] && hready && !hwrite) ? 1'b1 : (hreadyout ? 1'b0 : ph);
    end

    // Main sequence: trace and bus traffic contend, then trace gated, then read back
    initial begin
        void'($urandom(68031));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        noninvasive_debug_permit <= 1'b1;
        repeat (3) @(posedge core_clk);
        trace_enable_bit <= 1'b1;
        s_pend = 1'b1;
        fork
            for (int i = 0; i < 24; i++) trc(tbb_kind_t'(i % 6), 1'($urandom), $urandom, $urandom, $urandom);
            begin
                for (int i = 0; i < 16; i++) bus(1'b1, 32'h8000 + 32'(4 * i), 3'h2, $urandom);
                for (int i = 0; i < 40; i++) begin
                    bsz = 3'($urandom % 3);
                    ba = (32'h8000 + 32'($urandom % 64)) & ~((32'h1 << bsz) - 32'h1);
                    bus(1'b1, ba, bsz, $urandom);
                    bus(1'b0, ba & ~32'h3, 3'h2, 32'h0);
                end
            end
        join
        @(posedge core_clk);
        trace_enable_bit <= 1'b0;
        trc(EV_BRANCH, 1'b1, $urandom, $urandom, $urandom);
        // Enable back on but permit pin low: report must still be dropped
        trace_enable_bit <= 1'b1;
        noninvasive_debug_permit <= 1'b0;
        repeat (3) @(posedge core_clk);
        trc(EV_BRANCH, 1'b1, $urandom, $urandom, $urandom);
        noninvasive_debug_permit <= 1'b1;
        s_pend = 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 6; i++) trc(tbb_kind_t'(i), 1'b1, $urandom, $urandom, $urandom);
        repeat (6) @(posedge core_clk);
        for (int i = 0; i < ptr; i++) bus(1'b0, 32'(4 * i), 3'h2, 32'h0);
        repeat (2) @(posedge core_clk);
        conclude();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
endmodule : tbb_trace_bridge_tb
`default_nettype wire
